// File: design/ulrx_consts.svh
// Constants of the ULPI register read and status byte logic.
// Assumes inclusion by bare name from package and design files.
`ifndef ULRX_CONSTS_SVH
`define ULRX_CONSTS_SVH

// Command byte fields
`define ULRX_CMD_TYPE_MSB   7
`define ULRX_CMD_TYPE_LSB   6
`define ULRX_CMD_READ       2'h3
`define ULRX_ADDR_ESCAPE    6'h2F
`define ULRX_BUS_IDLE       8'h00

// Status byte field positions
`define ULRX_ST_LINE_LSB    0
`define ULRX_ST_VBUS_LSB    2
`define ULRX_ST_EVENT_LSB   4
`define ULRX_ST_ID_BIT      6
`define ULRX_ST_ALT_BIT     7

// Encodings of the status byte fields
`define ULRX_VBUS_BELOW_END 2'h0
`define ULRX_VBUS_END_VALID 2'h1
`define ULRX_VBUS_SESSION   2'h2
`define ULRX_VBUS_VALID     2'h3
`define ULRX_EVT_NONE       2'h0
`define ULRX_EVT_ACTIVE     2'h1
`define ULRX_EVT_ERROR      2'h3
`define ULRX_EVT_DISCONNECT 2'h2
`define ULRX_LS_SE0         2'h0
`define ULRX_LS_J           2'h1
`define ULRX_LS_K           2'h2

// Reset values of the outputs
`define ULRX_DIR_RESET      1'b1
`define ULRX_NXT_RESET      1'b0
`define ULRX_DATA_RESET     8'h00

`endif

// File: design/ulrx_pkg.sv
// Types of the ULPI register read and status byte logic.
// Assumes the constants header sits beside it.
package ulrx_pkg;
`include "ulrx_consts.svh"

   // Line receiver interpretation in use
   typedef enum logic [1:0] {
      ULRX_SPD_FS    = 2'h0,
      ULRX_SPD_LS    = 2'h1,
      ULRX_SPD_HS    = 2'h2,
      ULRX_SPD_CHIRP = 2'h3
   } ulrx_speed_t;

   // Bus protocol states, Gray from IDLE to BACK along the extended read path
   typedef enum logic [3:0] {
      ULRX_IDLE    = 4'h0,
      ULRX_CMD     = 4'h1,
      ULRX_ACK     = 4'h3,
      ULRX_EXT     = 4'h2,
      ULRX_TURN    = 4'h6,
      ULRX_DRIVE   = 4'h7,
      ULRX_BACK    = 4'h5,
      ULRX_RX_TURN = 4'h4,
      ULRX_RX_SEND = 4'hC,
      ULRX_START   = 4'h8
   } ulrx_state_t;
endpackage

// File: design/ulrx_phy_read.sv
// Transceiver side of the ULPI bus: register reads and status bytes.
// Assumes a register file on sys_clk answering regRdData from regAddr
// combinationally, and line and comparator levels arriving unsynced.
`timescale 1ns/10ps
`include "ulrx_consts.svh"

// Contract
// RQ1 - Link read command: 11b plus address
// RQ2 - NXT rises two cycles after command
// RQ3 - Next cycle: DIR up, NXT down
// RQ4 - After turnaround drive register for one cycle
// RQ5 - Link samples, PHY drops DIR
// RQ6 - Link drives idle after turnaround
// RQ7 - Extended read: escape, address after NXT
// RQ8 - Extended: capture address, then read sequence
// RQ9 - Idle bus: status bytes by raising DIR
// RQ10 - Status on line, VBUS, ID change
// RQ11 - Status every DIR-high NXT-low receive cycle
// RQ12 - Status after startup and leaving low power
// RQ13 - Status deferred during transmit, sent current
// RQ14 - Bits 1:0 carry line state
// RQ15 - Bits 3:2 encode VBUS level
// RQ16 - Bits 5:4 encode receive events
// RQ17 - Bit 6 is ID pin level
// RQ18 - Bit 7 flags unmasked alternate interrupt
// RQ19 - LS/FS line state from SE receivers
// RQ20 - Low speed idle is K
// RQ21 - High speed line state reports squelch
// RQ22 - Chirp line state from squelch, differential
// RQ23 - One turnaround cycle per DIR change
// RQ24 - Read 11b, escape 101111b extended
// RQ25 - Link starts access only DIR low
// RQ26 - Single data rate, rising edge
// RQ27 - Status deferred until read finishes
module ulrx_phy_read
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // ULPI bus
   input  wire logic [7:0]        dataIn,
   output logic      [7:0]        dataOut,
   output logic                   dataOe,
   output logic                   dir,
   output logic                   nxt,
   input  wire logic              stp,
   // Register file read port
   output logic      [7:0]        regAddr,
   output logic                   regRdStrobe,
   input  wire logic [7:0]        regRdData,
   // Analog levels, unsynchronised
   input  wire logic              dpSeRx,
   input  wire logic              dmSeRx,
   input  wire logic              squelch,
   input  wire logic              hsDiffRx,
   input  wire logic              sessionEndFlag,
   input  wire logic              sessionValidFlag,
   input  wire logic              busPowerValidFlag,
   input  wire logic              idPin,
   // Core state on sys_clk
   input  wire ulrx_pkg::ulrx_speed_t speedMode,
   input  wire logic              rxActive,
   input  wire logic              rxError,
   input  wire logic              hostDisconnectFlag,
   input  wire logic              altIntPending,
   input  wire logic              txActive,
   input  wire logic              phyReady,
   input  wire logic              lowPowerActive,
   // Status
   output logic                   lineIsIdle,
   output logic                   readBusy
);
   import ulrx_pkg::*;

   localparam int SYNC_W = 8;

   ulrx_state_t       state_reg;     // Bus protocol state
   logic [SYNC_W-1:0] syncA_reg;     // First stage, read by second only
   logic [SYNC_W-1:0] syncB_reg;     // Second stage
   logic [SYNC_W-1:0] syncC_reg;     // Third stage
   logic [SYNC_W-1:0] pinLvl_reg;    // Filtered pin levels
   logic [SYNC_W-1:0] pinLvl_next;   // Filter result
   logic [1:0]        lineState;     // Decoded line state
   logic [1:0]        vbusCode;      // Encoded VBUS level
   logic [1:0]        eventCode;     // Encoded receive event
   logic [7:0]        status;        // Status byte, current
   logic [7:0]        statusPrev_reg;// Last seen status byte
   logic              pending_reg;   // Status byte owed to the Link
   logic              extRead_reg;   // Read uses escape address
   logic              lowPrev_reg;   // Low power level, delayed
   logic              resumeWait_reg;// Left low power, waiting STP low
   logic              txPrev_reg;    // Transmit level, delayed
   logic              busIdle;       // Link drives idle, DIR low
   logic              sendNow;       // Status byte driven this edge
   logic              startSet;      // Startup handover owes a byte
   logic              stsEvent;      // Any status event this cycle

   // Pin vector order
   logic [SYNC_W-1:0] pinRaw;
   assign pinRaw = {idPin, busPowerValidFlag, sessionValidFlag,
                    sessionEndFlag, hsDiffRx, squelch, dmSeRx, dpSeRx};

   // Three-stage synchroniser for every analog level
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
         syncC_reg <= '0;
      end else begin
         syncA_reg <= pinRaw;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
      end
   end

   // A bit changes once stages two and three agree; glitches die here
   always_comb begin
      for (int i = 0; i < SYNC_W; i++) begin
         pinLvl_next[i] = (syncB_reg[i] == syncC_reg[i]) ?
                          syncC_reg[i] : pinLvl_reg[i];
      end
   end

   // Filtered level register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pinLvl_reg <= '0;
      end else begin
         pinLvl_reg <= pinLvl_next;
      end
   end

   // Line state by speed mode
   always_comb begin
      unique case (speedMode)
         ULRX_SPD_HS: begin
            lineState = pinLvl_reg[2] ? `ULRX_LS_SE0 : `ULRX_LS_J; // [RQ21]
         end
         ULRX_SPD_CHIRP: begin
            lineState = pinLvl_reg[2] ? `ULRX_LS_SE0 :      // [RQ22]
                        (pinLvl_reg[3] ? `ULRX_LS_J : `ULRX_LS_K);
         end
         default: begin
            // Plus line in bit zero, minus line in bit one
            lineState = {pinLvl_reg[1], pinLvl_reg[0]};     // [RQ19]
         end
      endcase
   end

   // VBUS encoding, highest comparator wins
   always_comb begin
      vbusCode = pinLvl_reg[6] ? `ULRX_VBUS_VALID   :       // [RQ15]
                 pinLvl_reg[5] ? `ULRX_VBUS_SESSION :
                 pinLvl_reg[4] ? `ULRX_VBUS_BELOW_END : `ULRX_VBUS_END_VALID;
   end

   // Receive event encoding; disconnect outranks receive activity
   always_comb begin
      eventCode = hostDisconnectFlag ? `ULRX_EVT_DISCONNECT : // [RQ16]
                  !rxActive          ? `ULRX_EVT_NONE       :
                  rxError            ? `ULRX_EVT_ERROR      : `ULRX_EVT_ACTIVE;
   end

   // Status byte assembled from current levels
   always_comb begin
      status = '0;
      status[`ULRX_ST_LINE_LSB +: 2]  = lineState;          // [RQ14]
      status[`ULRX_ST_VBUS_LSB +: 2]  = vbusCode;           // [RQ15]
      status[`ULRX_ST_EVENT_LSB +: 2] = eventCode;          // [RQ16]
      status[`ULRX_ST_ID_BIT]         = pinLvl_reg[7];      // [RQ17]
      status[`ULRX_ST_ALT_BIT]        = altIntPending;      // [RQ18]
   end

   // Bus idle seen by the PHY; turnaround cycles are never sampled
   assign busIdle = (state_reg == ULRX_IDLE) &&
                    (dataIn == `ULRX_BUS_IDLE);             // [RQ23]
   assign sendNow = (state_reg == ULRX_RX_SEND);
   assign startSet = (state_reg == ULRX_START) && phyReady && !stp;
   assign stsEvent = (status != statusPrev_reg)             // [RQ10]
                || startSet                                 // [RQ12]
                || (resumeWait_reg && !stp && !dir)         // [RQ12]
                || (txPrev_reg && !txActive);               // [RQ13]

   // Change detection and transmit / low power edge memory
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         statusPrev_reg <= '0;
         txPrev_reg     <= 1'b0;
         lowPrev_reg    <= 1'b0;
      end else begin
         statusPrev_reg <= status;
         txPrev_reg     <= txActive;
         lowPrev_reg    <= lowPowerActive;
      end
   end

   // Leaving low power arms a byte that waits for STP low, DIR low
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resumeWait_reg <= 1'b0;
      end else if (lowPrev_reg && !lowPowerActive) begin
         resumeWait_reg <= 1'b1;
      end else if (!stp && !dir) begin
         resumeWait_reg <= 1'b0;                            // [RQ12]
      end
   end

   // Owed status byte; a new event wins over the clear of sending
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pending_reg <= 1'b0;
      end else if (stsEvent) begin
         pending_reg <= 1'b1;
      end else if (sendNow) begin
         pending_reg <= 1'b0;
      end
   end

   // Idle level per speed; low speed idles in K
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         lineIsIdle <= 1'b0;
      end else if (speedMode == ULRX_SPD_LS) begin
         lineIsIdle <= (lineState == `ULRX_LS_K);           // [RQ20]
      end else if (speedMode == ULRX_SPD_FS) begin
         lineIsIdle <= (lineState == `ULRX_LS_J);
      end else begin
         lineIsIdle <= (lineState == `ULRX_LS_SE0);
      end
   end

   // Protocol sequencer; every transfer on the rising edge   [RQ26]
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg   <= ULRX_START;
         dir         <= `ULRX_DIR_RESET;
         nxt         <= `ULRX_NXT_RESET;
         dataOut     <= `ULRX_DATA_RESET;
         dataOe      <= 1'b0;
         regAddr     <= '0;
         regRdStrobe <= 1'b0;
         extRead_reg <= 1'b0;
         readBusy    <= 1'b0;
      end else begin
         regRdStrobe <= 1'b0;
         unique case (state_reg)
            ULRX_START: begin
               // DIR held high until the core is ready and STP is low
               if (phyReady && !stp) begin
                  dir       <= 1'b0;                        // [RQ12]
                  state_reg <= ULRX_BACK;
               end
            end
            ULRX_IDLE: begin
               // Commands only count while DIR is low          [RQ25]
               if (lowPowerActive) begin
                  state_reg <= ULRX_IDLE;
               end else if (dataIn[`ULRX_CMD_TYPE_MSB:`ULRX_CMD_TYPE_LSB]
                            == `ULRX_CMD_READ) begin        // [RQ1] [RQ24]
                  regAddr     <= {2'b00, dataIn[5:0]};
                  extRead_reg <= (dataIn[5:0] == `ULRX_ADDR_ESCAPE);
                  readBusy    <= 1'b1;
                  state_reg   <= ULRX_CMD;
               end else if (rxActive ||
                            (pending_reg && !txActive && busIdle)) begin
                  // Receive activity sends at once; owed status only on an idle bus, outside transmits
                  dir       <= 1'b1;                        // [RQ9] [RQ13]
                  state_reg <= ULRX_RX_TURN;
               end
            end
            ULRX_CMD: begin
               nxt       <= 1'b1;                           // [RQ2]
               state_reg <= ULRX_ACK;
            end
            ULRX_ACK: begin
               if (extRead_reg) begin
                  // Keep NXT high; the address byte comes next [RQ7]
                  state_reg <= ULRX_EXT;
               end else begin
                  dir         <= 1'b1;                      // [RQ3]
                  nxt         <= 1'b0;
                  regRdStrobe <= 1'b1;
                  state_reg   <= ULRX_TURN;
               end
            end
            ULRX_EXT: begin
               regAddr     <= dataIn;                       // [RQ8]
               dir         <= 1'b1;
               nxt         <= 1'b0;
               regRdStrobe <= 1'b1;
               state_reg   <= ULRX_TURN;
            end
            ULRX_TURN: begin
               // Turnaround over; drive the register value    [RQ23]
               dataOut   <= regRdData;                      // [RQ4] [RQ8]
               dataOe    <= 1'b1;
               state_reg <= ULRX_DRIVE;
            end
            ULRX_DRIVE: begin
               // Link samples now; hand the bus back           [RQ5]
               dir       <= 1'b0;
               dataOe    <= 1'b0;
               dataOut   <= `ULRX_DATA_RESET;
               readBusy  <= 1'b0;
               state_reg <= ULRX_BACK;
            end
            ULRX_BACK: begin
               // Turnaround; owed status waits here [RQ6] [RQ23] [RQ27]
               state_reg <= ULRX_IDLE;
            end
            ULRX_RX_TURN: begin
               dataOut   <= status;                         // [RQ13]
               dataOe    <= 1'b1;
               state_reg <= ULRX_RX_SEND;
            end
            ULRX_RX_SEND: begin
               // Back to back while receiving or still owed  [RQ9] [RQ11]
               if (rxActive || stsEvent) begin
                  dataOut <= status;
               end else begin
                  dir       <= 1'b0;
                  dataOe    <= 1'b0;
                  dataOut   <= `ULRX_DATA_RESET;
                  state_reg <= ULRX_BACK;
               end
            end
            default: begin
               // Unused codes recover through a turnaround
               dir       <= 1'b0;
               nxt       <= 1'b0;
               dataOe    <= 1'b0;
               state_reg <= ULRX_BACK;
            end
         endcase
      end
   end

endmodule // ulrx_phy_read

// File: tb/ulrx_phy_read_asserts.sv
// Bus timing checker for the transceiver read and status byte block.
// Assumes one clock domain and the port names of ulrx_phy_read.
`timescale 1ns/10ps
module ulrx_phy_read_asserts (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rstn,
   // Bus seen at the pins
   input wire logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic       dataOe,
   input wire logic       dir,
   input wire logic       nxt,
   // Register file port and core state
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regRdData,
   input wire logic       rxActive,
   input wire logic       txActive,
   // Read progress outputs
   input wire logic       regRdStrobe,
   input wire logic       readBusy
);
   logic [7:0] dataQ1_reg;  // Link byte one edge back
   logic [7:0] dataQ2_reg;  // Link byte two edges back

   // Keep the command that NXT answers two edges later
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dataQ1_reg <= 8'h00;
         dataQ2_reg <= 8'h00;
      end else begin
         dataQ1_reg <= dataIn;
         dataQ2_reg <= dataQ1_reg;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   cmd_nxt_a: assert property (
      $rose(nxt) |-> dataQ2_reg[7:6] == 2'h3)
      else $error("NXT rose without a read command");
   imm_turn_a: assert property (
      $rose(nxt) && dataQ2_reg[5:0] != 6'h2F |=> dir && !nxt)
      else $error("Immediate read did not take the bus");
   reg_addr_a: assert property (
      $rose(nxt) && dataQ2_reg[5:0] != 6'h2F
      |-> regAddr == {2'h0, dataQ2_reg[5:0]})
      else $error("Read address not taken from command");
   ext_nxt_a: assert property (
      $rose(nxt) && dataQ2_reg[5:0] == 6'h2F |=> nxt ##1 (dir && !nxt))
      else $error("Extended read handshake wrong");
   data_drive_a: assert property (
      $rose(dir) && $past(nxt) |=> dataOe && dataOut == regRdData)
      else $error("Register value not driven after turnaround");
   dir_drop_a: assert property (
      $rose(dir) && $past(nxt) |-> ##2 !dir && !dataOe)
      else $error("DIR not dropped after read data");
   turn_in_a: assert property (
      $rose(dir) |-> !dataOe)
      else $error("Bus driven in turnaround after DIR rose");
   turn_out_a: assert property (
      $fell(dir) |-> !dataOe)
      else $error("Bus driven after DIR fell");
   rx_stream_a: assert property (
      rxActive[*8] ##1 rxActive[*4] |-> dir && dataOe && !nxt)
      else $error("Receive cycle without a status byte");
   tx_hold_a: assert property (
      $rose(dir) && !$past(nxt) |-> !$past(txActive))
      else $error("Status byte started during transmit");
   strobe_turn_a: assert property (
      $rose(dir) && $past(nxt) |-> regRdStrobe)
      else $error("Register read strobe missing as DIR rose");
   busy_nxt_a: assert property (
      $rose(nxt) |-> readBusy)
      else $error("NXT rose outside a register read");
   read_defer_a: assert property (
      $rose(dir) && !$past(nxt) |-> !$past(readBusy))
      else $error("Status byte started during a register read");

   cover property ($rose(nxt) && dataQ2_reg[5:0] == 6'h2F);
   cover property ($rose(nxt) && dataQ2_reg[5:0] != 6'h2F);
   cover property ($rose(dir) && !$past(nxt));
   cover property (rxActive && dataOe);
endmodule // ulrx_phy_read_asserts

bind ulrx_phy_read ulrx_phy_read_asserts u_chk (.sys_clk, .rstn, .dataIn,
   .dataOut, .dataOe, .dir, .nxt, .regAddr, .regRdData, .rxActive,
   .txActive, .regRdStrobe, .readBusy);

// File: tb/ulrx_link_model.sv
// Link controller model: issues register reads, collects status bytes.
// Assumes the transceiver on the same clock; bench raises start per read.
`timescale 1ns/10ps
module ulrx_link_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Transceiver side of the bus
   input  wire logic        dir,
   input  wire logic        nxt,
   input  wire logic [7:0]  dataOut,
   output logic      [7:0]  dataIn,
   // Bench request side
   input  wire logic        start,
   input  wire logic [7:0]  addr,
   output logic             done,
   output logic      [7:0]  rdData,
   output logic      [7:0]  lastSts,
   output logic      [15:0] stsCnt
);
   logic [2:0] st_reg;    // Read step
   logic [7:0] bus_reg;   // Byte driven while the Link owns the bus
   logic [7:0] pat_reg;   // Junk while released, flips every cycle
   logic       drv_reg;   // Link owns the bus
   logic       dirQ_reg;  // DIR at the previous edge
   logic       ext;       // Address needs the extended form

   assign ext = addr[7:6] != 2'h0 || addr[5:0] == 6'h2F;
   // A stale byte must never pass for data, hence the flipping junk
   assign dataIn = drv_reg ? bus_reg : pat_reg;

   // Bus ownership, read sequence and status capture
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg   <= 3'h0;
         bus_reg  <= 8'h00;
         pat_reg  <= 8'h5A;
         drv_reg  <= 1'b0;
         dirQ_reg <= 1'b1;
         done     <= 1'b0;
         rdData   <= 8'h00;
         lastSts  <= 8'h00;
         stsCnt   <= 16'h0000;
      end else begin
         pat_reg  <= ~pat_reg;
         dirQ_reg <= dir;
         drv_reg  <= !dir; // Idle byte after one turnaround
         done     <= 1'b0;
         if (dir && dirQ_reg && st_reg != 3'h4) begin
            lastSts <= dataOut;
            stsCnt  <= stsCnt + 16'h0001;
         end
         case (st_reg)
            3'h0: if (start && !dir && drv_reg) begin
               bus_reg <= ext ? 8'hEF : {2'h3, addr[5:0]};
               st_reg  <= 3'h1;
            end
            3'h1: if (dir && !nxt) begin // Lost to a status byte: retry
               bus_reg <= 8'h00;
               st_reg  <= 3'h0;
            end else if (nxt) begin
               bus_reg <= ext ? addr : 8'h00;
               st_reg  <= ext ? 3'h2 : 3'h3;
            end
            3'h2: begin
               bus_reg <= 8'h00;
               st_reg  <= 3'h3;
            end
            3'h3: if (dir) st_reg <= 3'h4;
            3'h4: begin // Second DIR-high edge carries the value
               rdData <= dataOut;
               done   <= 1'b1;
               st_reg <= 3'h5;
            end
            default: if (!start) st_reg <= 3'h0;
         endcase
      end
   end
endmodule // ulrx_link_model

// File: tb/tb.sv
// Self-checking bench for the transceiver read and status byte block.
// Assumes the package, design and link model are compiled first.
`timescale 1ns/10ps
module tb;
   import ulrx_pkg::*;
   logic        sys_clk = 1'b0;  // 50 MHz clock
   logic        rstn, stp, start, done, dir, nxt, dataOe, regRdStrobe;
   logic        phyReady, txActive, lowPowerActive, lineIsIdle, readBusy;
   logic [7:0]  dataIn, dataOut, regAddr, regRdData, addr, rdData, lastSts;
   logic [13:0] cfg;     // dp dm sq hd se sv bv id spd rxA rxE hdis alt
   logic [15:0] stsCnt;  // Status bytes seen by the link
   logic [15:0] n;       // Count before a step
   int          fail_count, cmp_count;
   logic [7:0]  adr [6] = '{8'h05, 8'h3F, 8'h2F, 8'hC3, 8'h00, 8'h6E};
   // Each entry differs from the last, so each one owes a status byte
   logic [13:0] tbl [11] = '{14'h1100, 14'h1210, 14'h3000, 14'h00E0,
      14'h08E0, 14'h0430, 14'h0031, 14'h2082, 14'h2088, 14'h208C, 14'h2080};

   assign regRdData = regAddr ^ 8'hA5; // Register file stand-in
   always #10 sys_clk = ~sys_clk;

   ulrx_phy_read DUT (.sys_clk, .rstn, .dataIn, .dataOut, .dataOe, .dir,
      .nxt, .stp, .regAddr, .regRdStrobe, .regRdData, .dpSeRx(cfg[13]),
      .dmSeRx(cfg[12]), .squelch(cfg[11]), .hsDiffRx(cfg[10]),
      .sessionEndFlag(cfg[9]), .sessionValidFlag(cfg[8]),
      .busPowerValidFlag(cfg[7]), .idPin(cfg[6]),
      .speedMode(ulrx_speed_t'(cfg[5:4])), .rxActive(cfg[3]),
      .rxError(cfg[2]), .hostDisconnectFlag(cfg[1]),
      .altIntPending(cfg[0]), .txActive, .phyReady, .lowPowerActive,
      .lineIsIdle, .readBusy);
   ulrx_link_model u_link (.sys_clk, .rstn, .dir, .nxt, .dataOut, .dataIn,
      .start, .addr, .done, .rdData, .lastSts, .stsCnt);

   // Status byte expected for one input setting
   function automatic logic [7:0] expSts(logic [13:0] c);
      logic [1:0] ln, vb, ev;
      case (c[5:4])
         2'h2: ln = {1'b0, !c[11]};
         2'h3: ln = c[11] ? 2'h0 : (c[10] ? 2'h1 : 2'h2);
         default: ln = {c[12], c[13]};
      endcase
      vb = c[7] ? 2'h3 : c[8] ? 2'h2 : c[9] ? 2'h0 : 2'h1;
      ev = c[1] ? 2'h2 : c[3] ? {c[2], 1'b1} : 2'h0;
      return {c[0], c[6], ev, vb, ln};
   endfunction
   // Idle line: K in low speed, J in full speed, 00 otherwise
   function automatic logic expIdle(logic [13:0] c);
      logic [7:0] s;
      s = expSts(c);
      return c[5:4] == 2'h1 ? s[1:0] == 2'h2 :
         c[5:4] == 2'h0 ? s[1:0] == 2'h1 : s[1:0] == 2'h0;
   endfunction

   task automatic check(logic [7:0] got, logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for a fresh status byte, then let syncs settle
   task automatic waitSts(logic [15:0] n0);
      for (int i = 0; i < 200 && stsCnt == n0; i++) @(posedge sys_clk);
      repeat (16) @(posedge sys_clk);
   endtask
   // One register read through the link
   task automatic rd(logic [7:0] a);
      addr  <= a;
      start <= 1'b1;
      for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge sys_clk);
      start <= 1'b0;
      check(rdData, a ^ 8'hA5);
      @(posedge sys_clk);
   endtask
   task automatic startup();
      repeat (3) @(posedge sys_clk);
      n = stsCnt;
      phyReady <= 1'b1;
      waitSts(n);
      check({7'h0, stsCnt != n}, 8'h01);
      check(lastSts, expSts(cfg));
   endtask
   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      stp = 1'b0;
      start = 1'b0;
      addr = 8'h00;
      phyReady = 1'b0;
      txActive = 1'b0;
      lowPowerActive = 1'b0;
      cfg = 14'h20C0;  // FS J, bus power valid, B device
      fail_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge sys_clk);
      check({dir, nxt, dataOe, 5'h00}, 8'h80); // Levels held in reset
      rstn <= 1'b1;
      startup();
      n = stsCnt;
      cfg <= 14'h20C1; // Event lands as the reads start
      foreach (adr[i]) rd(adr[i]);
      waitSts(n);
      check(lastSts, expSts(cfg));
      foreach (tbl[i]) begin
         n = stsCnt;
         cfg <= tbl[i];
         waitSts(n);
         check(lastSts, expSts(tbl[i]));
         check({7'h0, lineIsIdle}, {7'h0, expIdle(tbl[i])});
      end
      txActive <= 1'b1;
      @(posedge sys_clk);
      n = stsCnt;
      cfg <= cfg ^ 14'h0040; // ID change held back while sending
      repeat (20) @(posedge sys_clk);
      check(stsCnt[7:0] - n[7:0], 8'h00);
      txActive <= 1'b0;
      waitSts(n);
      check(lastSts, expSts(cfg));
      lowPowerActive <= 1'b1;
      stp <= 1'b1;
      repeat (4) @(posedge sys_clk);
      n = stsCnt;
      lowPowerActive <= 1'b0;
      @(posedge sys_clk);
      stp <= 1'b0;
      waitSts(n);
      check({7'h0, stsCnt != n}, 8'h01);
      rstn <= 1'b0; // Second reset in mid-run
      phyReady <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      startup();
      rd(8'h81);
      finish_test();
   end

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      finish_test();
   end
endmodule // tb
